//--- hw/plc_consts.svh
// Named constants for the port LED and output control block.
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH
`define PLC_CLK_NS 10
`define PLC_TICK_NS 2500000
`define PLC_BLINK_MIN 8'h01
`define PLC_BRIGHT_RST 8'h00
`define PLC_TIME_RST 8'h01
`define PLC_PWM_STEP 8'h01
`define PLC_PRI_VAL_RST 4'hf
`define PLC_SEC_VAL_RST 4'h0
`define PLC_EN_RST 4'h0
`define PLC_STRAP_SETTLE 2'h3
`define PLC_STRAP_STEP 2'h1
`endif

//--- hw/plc_pkg.sv
// Types shared by the port LED and output control block.
package plc_pkg;
  typedef enum logic [1:0] {
    PLC_LED_OFF,
    PLC_LED_ON,
    PLC_LED_PWM,
    PLC_LED_BLINK
  } plc_led_mode_t;
  typedef enum logic [1:0] {
    PLC_SCOPE_PORT,
    PLC_SCOPE_DEVICE,
    PLC_SCOPE_BCAST,
    PLC_SCOPE_NONE
  } plc_scope_t;
endpackage

//--- hw/plc_tb_if.sv
// Shared LED timebase carried from the top to each LED channel.
`timescale 1ns/1ps
`default_nettype none
interface plc_tb_if;
  logic tick;
  logic [7:0] pwm_cnt;
  modport src (output tick, output pwm_cnt);
  modport sink (input tick, input pwm_cnt);
endinterface
`default_nettype wire

//--- hw/plc_led_chan.sv
// One LED channel: static, dimmed and blinking modes.
`timescale 1ns/1ps
`default_nettype none
`include "plc_consts.svh"
module plc_led_chan (
  input wire logic clk,
  input wire logic rst,
  plc_tb_if.sink tb,
  input wire plc_pkg::plc_led_mode_t mode,
  input wire logic [7:0] bright,
  input wire logic [7:0] on_time,
  input wire logic [7:0] off_time,
  output logic lit
);
  import plc_pkg::*;
  logic [7:0] cnt_r, cnt_nxt;
  logic phase_r, phase_nxt;
  logic lit_nxt;
  wire pwm_hit = tb.pwm_cnt < bright;
  wire [7:0] cur_len = phase_r ? on_time : off_time;
  // A zero time is served as the shortest phase rather than a stuck one.
  wire [7:0] len = (cur_len < `PLC_BLINK_MIN) ? `PLC_BLINK_MIN : cur_len;
  wire [7:0] cnt_inc = cnt_r + `PLC_PWM_STEP;
  wire phase_end = tb.tick && (cnt_inc >= len);

  always_comb begin
    cnt_nxt = cnt_r;
    phase_nxt = phase_r;
    if (mode != PLC_LED_BLINK) begin
      cnt_nxt = '0;
      phase_nxt = 1'b1;
    end else if (phase_end) begin
      cnt_nxt = '0;
      phase_nxt = ~phase_r;
    end else if (tb.tick) begin
      cnt_nxt = cnt_inc;
    end
  end

  always_comb begin
    unique case (mode)
      PLC_LED_OFF: lit_nxt = 1'b0;
      PLC_LED_ON: lit_nxt = 1'b1;
      PLC_LED_PWM: lit_nxt = pwm_hit;
      PLC_LED_BLINK: lit_nxt = phase_r & pwm_hit;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      phase_r <= 1'b1;
      lit <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      phase_r <= phase_nxt;
      lit <= lit_nxt;
    end
  end

  property p_pwm_compare;
    @(posedge clk) disable iff (rst)
      mode == PLC_LED_PWM |=> lit == ($past(tb.pwm_cnt) < $past(bright));
  endproperty
  a_pwm_compare: assert property (p_pwm_compare)
    else $error("PWM output does not follow counter compare");

  property p_blink_flip;
    @(posedge clk) disable iff (rst)
      mode == PLC_LED_BLINK && $stable(mode) && phase_end
        |=> phase_r != $past(phase_r);
  endproperty
  a_blink_flip: assert property (p_blink_flip)
    else $error("Blink phase did not change at end of its time");

  property p_dark_zero;
    @(posedge clk) disable iff (rst)
      mode != PLC_LED_ON && bright == `PLC_BRIGHT_RST |=> !lit;
  endproperty
  a_dark_zero: assert property (p_dark_zero)
    else $error("LED lit with zero brightness");

  c_blink_flip: cover property (@(posedge clk) disable iff (rst)
    mode == PLC_LED_BLINK && phase_end);
endmodule
`default_nettype wire

//--- hw/plc_top.sv
// Per-port LED driver, LED timebase sharing and general-purpose outputs.
`timescale 1ns/1ps
`default_nettype none
`include "plc_consts.svh"
module plc_top #(
  parameter int TICK_CYCLES = `PLC_TICK_NS / `PLC_CLK_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_timebase_clk,
  input wire logic host_protocol_strap,
  input wire logic dev_sel,
  input wire logic led_cfg_wr,
  input wire logic [2:0] led_cfg_idx,
  input wire plc_pkg::plc_led_mode_t led_cfg_mode,
  input wire logic [7:0] led_cfg_bright,
  input wire logic [7:0] led_cfg_on,
  input wire logic [7:0] led_cfg_off,
  input wire logic ts_use_ext,
  input wire logic ts_sync_master,
  input wire logic ts_chain_first,
  input wire logic out_wr,
  input wire plc_pkg::plc_scope_t out_scope,
  input wire logic out_target_val,
  input wire logic [1:0] out_port,
  input wire logic [1:0] out_data,
  output logic host_mode_spi,
  output logic strap_valid,
  output logic [3:0] led_drive_c,
  output logic [3:0] led_drive_d,
  output logic led_oe_n,
  output logic led_clock_sync_pin_o,
  output logic led_clock_sync_pin_oe_n,
  output logic chain_clock_out,
  output logic [3:0] port_out_primary,
  output logic [3:0] port_out_primary_oe_n,
  output logic [3:0] port_out_secondary,
  output logic [3:0] port_out_secondary_oe_n
);
  import plc_pkg::*;
  localparam int TW = $clog2(TICK_CYCLES);

  // Fewer than four cycles leaves no room for a half-period wave.
  if (TICK_CYCLES < 4) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 4");
  end

  // Strap capture: synchronised, then caught once after reset release.
  logic strap_s1_r, strap_s2_r;
  logic [1:0] settle_r;
  wire settle_done = settle_r == `PLC_STRAP_SETTLE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
    end else begin
      strap_s1_r <= host_protocol_strap;
      strap_s2_r <= strap_s1_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_r <= '0;
      strap_valid <= 1'b0;
      host_mode_spi <= 1'b0;
    end else if (!settle_done) begin
      settle_r <= settle_r + `PLC_STRAP_STEP;
    end else if (!strap_valid) begin
      strap_valid <= 1'b1;
      host_mode_spi <= strap_s2_r;
    end
  end

  // External timebase: one toggle per rising link clock edge, crossed as an event.
  logic ext_tog_r;
  always_ff @(posedge ext_timebase_clk or posedge rst) begin
    if (rst) begin
      ext_tog_r <= 1'b0;
    end else begin
      ext_tog_r <= ~ext_tog_r;
    end
  end

  logic ext_s1_r, ext_s2_r, ext_s3_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_tog_r;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  wire ext_tick = ext_s2_r ^ ext_s3_r;

  // Internal timebase divider; its wave rises at each tick.
  logic [TW-1:0] div_r, rep_r;
  wire int_tick = div_r == TW'(TICK_CYCLES - 1);
  wire int_wave = div_r < TW'(TICK_CYCLES / 2);
  wire rep_wave = rep_r != '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= '0;
    end else if (int_tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + TW'(1);
    end
  end

  // A follower regenerates a half-tick pulse per received tick, so the
  // repeated clock keeps its shape however far down the chain it is.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rep_r <= '0;
    end else if (ext_tick) begin
      rep_r <= TW'(TICK_CYCLES / 2);
    end else if (rep_wave) begin
      rep_r <= rep_r - TW'(1);
    end
  end

  wire blink_tick = ts_use_ext ? ext_tick : int_tick;
  wire sync_drive = host_mode_spi & ts_sync_master;
  wire chain_nxt = ~host_mode_spi & (ts_chain_first ? int_wave : rep_wave);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_clock_sync_pin_o <= 1'b0;
      led_clock_sync_pin_oe_n <= 1'b1;
      chain_clock_out <= 1'b0;
    end else begin
      led_clock_sync_pin_o <= int_wave;
      led_clock_sync_pin_oe_n <= ~sync_drive;
      chain_clock_out <= chain_nxt;
    end
  end

  // PWM counter free-runs; one period is 256 clocks.
  logic [7:0] pwm_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_r <= '0;
    end else begin
      pwm_r <= pwm_r + `PLC_PWM_STEP;
    end
  end

  plc_tb_if tb ();
  assign tb.tick = blink_tick;
  assign tb.pwm_cnt = pwm_r;

  // LED configuration, index = port * 2 + (0 for c, 1 for d).
  plc_led_mode_t mode_r [8];
  logic [7:0] bright_r [8];
  logic [7:0] on_r [8];
  logic [7:0] off_r [8];
  logic [7:0] lit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        mode_r[i] <= PLC_LED_OFF;
        bright_r[i] <= `PLC_BRIGHT_RST;
        on_r[i] <= `PLC_TIME_RST;
        off_r[i] <= `PLC_TIME_RST;
      end
    end else if (led_cfg_wr) begin
      mode_r[led_cfg_idx] <= led_cfg_mode;
      bright_r[led_cfg_idx] <= led_cfg_bright;
      on_r[led_cfg_idx] <= led_cfg_on;
      off_r[led_cfg_idx] <= led_cfg_off;
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_led
    plc_led_chan u_chan (
      .clk(clk),
      .rst(rst),
      .tb(tb),
      .mode(mode_r[g]),
      .bright(bright_r[g]),
      .on_time(on_r[g]),
      .off_time(off_r[g]),
      .lit(lit[g])
    );
  end

  // Only these two pins see blink and dimming; the general outputs below
  // carry static levels alone.
  wire [3:0] lit_c = {lit[6], lit[4], lit[2], lit[0]};
  wire [3:0] lit_d = {lit[7], lit[5], lit[3], lit[1]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_oe_n <= 1'b1;
      led_drive_c <= '1;
      led_drive_d <= '1;
    end else begin
      led_oe_n <= 1'b0;
      led_drive_c <= ~lit_c;
      led_drive_d <= ~lit_d;
    end
  end

  // General-purpose outputs: one enable register, one value register.
  wire port_hit_ok = (out_scope == PLC_SCOPE_PORT) && dev_sel;
  wire dev_hit_ok = (out_scope == PLC_SCOPE_DEVICE) && dev_sel;
  wire bcast_ok = out_scope == PLC_SCOPE_BCAST;
  wire [3:0] port_onehot = 4'h1 << out_port;
  wire [3:0] hit = {4{out_wr}} & (port_hit_ok ? port_onehot :
                   (dev_hit_ok || bcast_ok) ? 4'hf : 4'h0);
  wire [3:0] en_hit = hit & {4{~out_target_val}};
  wire [3:0] val_hit = hit & {4{out_target_val}};
  wire [3:0] pri_d = {4{out_data[0]}};
  wire [3:0] sec_d = {4{out_data[1]}};
  logic [3:0] pri_en_r, sec_en_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pri_en_r <= `PLC_EN_RST;
      sec_en_r <= `PLC_EN_RST;
    end else begin
      pri_en_r <= (pri_en_r & ~en_hit) | (pri_d & en_hit);
      sec_en_r <= (sec_en_r & ~en_hit) | (sec_d & en_hit);
    end
  end

  // Enabling does not touch the value register, so a value written first
  // is the one that appears; the host must keep that order.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_out_primary <= `PLC_PRI_VAL_RST;
      port_out_secondary <= `PLC_SEC_VAL_RST;
      port_out_primary_oe_n <= ~`PLC_EN_RST;
      port_out_secondary_oe_n <= ~`PLC_EN_RST;
    end else begin
      port_out_primary <= (port_out_primary & ~val_hit) | (pri_d & val_hit);
      port_out_secondary <= (port_out_secondary & ~val_hit) |
                            (sec_d & val_hit);
      port_out_primary_oe_n <= ~((pri_en_r & ~en_hit) | (pri_d & en_hit));
      port_out_secondary_oe_n <= ~((sec_en_r & ~en_hit) | (sec_d & en_hit));
    end
  end

  property p_strap_hold;
    @(posedge clk) disable iff (rst)
      strap_valid |=> strap_valid && $stable(host_mode_spi);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("Host protocol changed after capture");

  property p_strap_catch;
    @(posedge clk) disable iff (rst)
      $rose(strap_valid) |-> host_mode_spi == $past(strap_s2_r);
  endproperty
  a_strap_catch: assert property (p_strap_catch)
    else $error("Captured protocol differs from strap");

  property p_led_polarity;
    @(posedge clk) disable iff (rst)
      ##1 led_drive_c == ~$past(lit_c) && led_drive_d == ~$past(lit_d);
  endproperty
  a_led_polarity: assert property (p_led_polarity)
    else $error("LED pin not the inverse of lit state");

  property p_led_enabled;
    @(posedge clk) disable iff (rst)
      $fell(rst) |-> led_oe_n && led_drive_c == 4'hf ##1 (!led_oe_n)[*4];
  endproperty
  a_led_enabled: assert property (p_led_enabled)
    else $error("LED pins not enabled high after reset");

  property p_gpo_reset;
    @(posedge clk) disable iff (rst)
      $fell(rst) |-> port_out_primary_oe_n == 4'hf &&
        port_out_secondary_oe_n == 4'hf && port_out_primary == 4'hf &&
        port_out_secondary == 4'h0;
  endproperty
  a_gpo_reset: assert property (p_gpo_reset)
    else $error("General outputs wrong after reset");

  property p_bcast_en;
    @(posedge clk) disable iff (rst)
      out_wr && out_scope == PLC_SCOPE_BCAST && !out_target_val
        |=> port_out_primary_oe_n == {4{~$past(out_data[0])}} &&
            port_out_secondary_oe_n == {4{~$past(out_data[1])}};
  endproperty
  a_bcast_en: assert property (p_bcast_en)
    else $error("Broadcast enable write not applied to all ports");

  property p_port_val;
    @(posedge clk) disable iff (rst)
      out_wr && out_scope == PLC_SCOPE_PORT && dev_sel && out_target_val
        |=> port_out_primary[$past(out_port)] == $past(out_data[0]) &&
            ($past(port_onehot) | (port_out_primary ^
             $past(port_out_primary))) == $past(port_onehot);
  endproperty
  a_port_val: assert property (p_port_val)
    else $error("Single-port value write wrong or leaked");

  property p_gpo_static;
    @(posedge clk) disable iff (rst)
      !$stable(port_out_secondary) |-> $past(out_wr);
  endproperty
  a_gpo_static: assert property (p_gpo_static)
    else $error("General output moved without a write");

  property p_sync_drive;
    @(posedge clk) disable iff (rst)
      sync_drive |=> !led_clock_sync_pin_oe_n &&
        led_clock_sync_pin_o == $past(int_wave);
  endproperty
  a_sync_drive: assert property (p_sync_drive)
    else $error("Sync pin not driven with internal timebase");

  property p_chain_head;
    @(posedge clk) disable iff (rst)
      !host_mode_spi && ts_chain_first |=> chain_clock_out == $past(int_wave);
  endproperty
  a_chain_head: assert property (p_chain_head)
    else $error("Chain head does not send internal timebase");

  property p_tick_period;
    @(posedge clk) disable iff (rst)
      int_tick |=> (!int_tick)[*3];
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("Internal tick repeats too soon");

  c_ext_tick: cover property (@(posedge clk) disable iff (rst)
    ts_use_ext && ext_tick);
  c_bcast: cover property (@(posedge clk) disable iff (rst)
    out_wr && bcast_ok);
  c_led_lit: cover property (@(posedge clk) disable iff (rst)
    led_drive_c[0] == 1'b0);
endmodule
`default_nettype wire

//--- tb/plc_tb_partner.sv
// Model of the neighbouring device that sources the shared LED timebase.
`timescale 1ns/1ps
`default_nettype none
module plc_tb_partner (
  input wire logic run,
  output logic link_clk
);
  // The timebase stands still low between runs, as a stopped source would.
  initial begin
    link_clk = 1'b0;
    #7;
    forever begin
      if (run) begin
        link_clk = 1'b1;
        #24;
        link_clk = 1'b0;
        #24;
      end else begin
        link_clk = 1'b0;
        #3;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/plc_tb_top.sv
// Self-checking testbench for the port LED and output control block.
`timescale 1ns/1ps
`default_nettype none
module plc_tb_top;
  import plc_pkg::*;
  localparam int TC = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b1;
  logic run = 1'b1;
  logic dev_sel = 1'b0;
  logic cwr = 1'b0;
  logic [2:0] cidx = 3'h0;
  plc_led_mode_t cmode = PLC_LED_OFF;
  logic [7:0] cbr = 8'h00;
  logic [7:0] con = 8'h01;
  logic [7:0] coff = 8'h01;
  logic use_ext = 1'b0;
  logic smaster = 1'b0;
  logic cfirst = 1'b0;
  logic owr = 1'b0;
  plc_scope_t oscope = PLC_SCOPE_NONE;
  logic otv = 1'b0;
  logic [1:0] oport = 2'h0;
  logic [1:0] odata = 2'h0;
  logic ext, spi, sval, led_oe_n, sync_o, sync_oe_n, chain_o;
  logic [3:0] ldc, ldd, pri, pri_oe_n, sec, sec_oe_n;
  int fail_count = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  plc_tb_partner part_u (.run(run), .link_clk(ext));
  plc_top #(.TICK_CYCLES(TC)) dut_u (.clk(clk), .rst(rst),
    .ext_timebase_clk(ext), .host_protocol_strap(strap), .dev_sel(dev_sel),
    .led_cfg_wr(cwr), .led_cfg_idx(cidx), .led_cfg_mode(cmode),
    .led_cfg_bright(cbr), .led_cfg_on(con), .led_cfg_off(coff),
    .ts_use_ext(use_ext), .ts_sync_master(smaster),
    .ts_chain_first(cfirst), .out_wr(owr), .out_scope(oscope),
    .out_target_val(otv), .out_port(oport), .out_data(odata),
    .host_mode_spi(spi), .strap_valid(sval), .led_drive_c(ldc),
    .led_drive_d(ldd), .led_oe_n(led_oe_n), .led_clock_sync_pin_o(sync_o),
    .led_clock_sync_pin_oe_n(sync_oe_n), .chain_clock_out(chain_o),
    .port_out_primary(pri), .port_out_primary_oe_n(pri_oe_n),
    .port_out_secondary(sec), .port_out_secondary_oe_n(sec_oe_n));
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Counts cycles in which the chosen signal is active: sync (sel 8) or chain (sel 9) high, LED pin (sel 0-7) low.
  task automatic cnt(input int sel, input int k, output int n);
    n = 0;
    repeat (k) begin
      @(negedge clk);
      if (sel == 8 && sync_o === 1'b1) n++;
      if (sel == 9 && chain_o === 1'b1) n++;
      if (sel < 8 && (sel[0] ? ldd[sel>>1] : ldc[sel>>1]) === 1'b0) n++;
    end
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst <= 1'b1;
    run <= 1'b1;
    strap <= s;
    cyc(6);
    chk(led_oe_n === 1'b1 && sync_oe_n === 1'b1, "pins float");
    chk({pri, sec, pri_oe_n, sec_oe_n} === 16'hf0ff, "gpo reset");
    @(posedge clk);
    rst <= 1'b0;
    run <= 1'b0;
    cyc(2);
    chk(led_oe_n === 1'b0 && {ldc, ldd} === 8'hff, "leds high");
    cyc(4);
    chk(sval === 1'b1 && spi === s, "strap capture");
  endtask
  task automatic led_wr(input int i, input plc_led_mode_t m,
                        input logic [7:0] b, input logic [7:0] on,
                        input logic [7:0] off);
    @(posedge clk);
    cwr <= 1'b1;
    cidx <= 3'(i);
    cmode <= m;
    cbr <= b;
    con <= on;
    coff <= off;
    @(posedge clk);
    cwr <= 1'b0;
    cyc(3);
  endtask
  task automatic t_static();
    for (int i = 0; i < 8; i++) begin
      led_wr(i, PLC_LED_ON, 8'h00, 8'h01, 8'h01);
      chk({ldd, ldc} === ~(8'h01 << ((i & 1) * 4 + (i >> 1))), "on");
      led_wr(i, PLC_LED_OFF, 8'hff, 8'h01, 8'h01);
      chk({ldd, ldc} === 8'hff, "off");
    end
  endtask
  task automatic t_pwm();
    logic [7:0] lv [4] = '{8'h00, 8'h01, 8'h80, 8'hff};
    int n;
    foreach (lv[j]) begin
      led_wr(3, PLC_LED_PWM, lv[j], 8'h01, 8'h01);
      cyc(20);
      cnt(3, 256, n);
      chk(n == int'(lv[j]), "pwm level");
    end
    led_wr(3, PLC_LED_OFF, 8'h00, 8'h01, 8'h01);
  endtask
  task automatic t_blink();
    int n;
    led_wr(1, PLC_LED_BLINK, 8'hff, 8'h02, 8'h03);
    cyc(100);
    cnt(1, 5 * TC, n);
    chk(n == 2 * TC || n == 2 * TC - 1, "blink 2/3");
    led_wr(1, PLC_LED_BLINK, 8'hff, 8'h01, 8'h04);
    cyc(100);
    cnt(1, 5 * TC, n);
    chk(n == TC || n == TC - 1, "blink 1/4");
    led_wr(1, PLC_LED_BLINK, 8'h00, 8'h01, 8'h01);
    cnt(1, 5 * TC, n);
    chk(n == 0, "blink dark");
  endtask
  task automatic t_ext();
    int n;
    @(posedge clk);
    use_ext <= 1'b1;
    run <= 1'b1;
    led_wr(4, PLC_LED_BLINK, 8'hff, 8'h01, 8'h01);
    cyc(50);
    cnt(4, 96, n);
    chk(n >= 40 && n <= 56, "ext blink");
    run <= 1'b0;
    cyc(20);
    cnt(4, 100, n);
    chk(n == 0 || n >= 99, "ext frozen");
    @(posedge clk);
    use_ext <= 1'b0;
    led_wr(4, PLC_LED_OFF, 8'h00, 8'h01, 8'h01);
  endtask
  task automatic t_sync_spi();
    int n;
    @(posedge clk);
    smaster <= 1'b1;
    cyc(3 * TC);
    chk(sync_oe_n === 1'b0 && chain_o === 1'b0, "sync drive");
    cnt(8, 4 * TC, n);
    chk(n == 2 * TC, "sync wave");
    @(posedge clk);
    smaster <= 1'b0;
    cyc(3);
    chk(sync_oe_n === 1'b1, "sync release");
  endtask
  task automatic t_chain();
    int n;
    @(posedge clk);
    cfirst <= 1'b1;
    cyc(3 * TC);
    cnt(9, 4 * TC, n);
    chk(n == 2 * TC && sync_oe_n === 1'b1, "chain head");
    @(posedge clk);
    cfirst <= 1'b0;
    use_ext <= 1'b1;
    run <= 1'b1;
    cyc(20);
    cnt(9, 4 * TC, n);
    // Link ticks come faster than half a period, so the repeat stays high.
    chk(n == 4 * TC, "chain repeat");
    run <= 1'b0;
    cyc(2 * TC);
    chk(chain_o === 1'b0, "chain idle");
  endtask
  task automatic gw(input plc_scope_t s, input logic tv, input logic [1:0] p,
                    input logic [1:0] d, input logic ds,
                    input logic [15:0] e);
    @(posedge clk);
    owr <= 1'b1;
    oscope <= s;
    otv <= tv;
    oport <= p;
    odata <= d;
    dev_sel <= ds;
    @(posedge clk);
    owr <= 1'b0;
    cyc(2);
    chk({pri, sec, pri_oe_n, sec_oe_n} === e, "gpo write");
  endtask
  task automatic t_gpo();
    gw(PLC_SCOPE_PORT, 1'b1, 2'h2, 2'h2, 1'b1, 16'hb4ff);
    gw(PLC_SCOPE_PORT, 1'b1, 2'h1, 2'h2, 1'b0, 16'hb4ff);
    gw(PLC_SCOPE_NONE, 1'b1, 2'h0, 2'h0, 1'b1, 16'hb4ff);
    gw(PLC_SCOPE_DEVICE, 1'b0, 2'h0, 2'h1, 1'b1, 16'hb40f);
    gw(PLC_SCOPE_BCAST, 1'b1, 2'h0, 2'h1, 1'b0, 16'hf00f);
    gw(PLC_SCOPE_DEVICE, 1'b0, 2'h0, 2'h3, 1'b0, 16'hf00f);
    gw(PLC_SCOPE_PORT, 1'b0, 2'h3, 2'h2, 1'b1, 16'hf087);
    gw(PLC_SCOPE_BCAST, 1'b0, 2'h0, 2'h1, 1'b0, 16'hf00f);
  endtask
  // A hang is cut short well beyond the expected run of a few thousand cycles.
  initial begin
    #300000;
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    do_reset(1'b1);
    t_sync_spi();
    t_static();
    t_pwm();
    t_blink();
    t_ext();
    t_gpo();
    do_reset(1'b0);
    t_chain();
    tally_and_finish();
  end
endmodule
`default_nettype wire
